// ===== ads_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// result buffer with registered read data
module ads_fifo
   import ads_pkg::*;
#(
   parameter int WIDTH = ADS_WORD_W,
   parameter int DEPTH = ADS_FIFO_DEPTH
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic wr_valid,
   output logic wr_ready,
   output logic [WIDTH-1:0] rd_data,
   output logic rd_valid,
   input wire logic rd_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wp_ff, nxt_wp;
   logic [AW-1:0] rp_ff, nxt_rp;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic [WIDTH-1:0] out_data_ff, nxt_out_data;
   logic out_valid_ff, nxt_out_valid;
   logic wr_ready_ff, nxt_wr_ready;
   logic push;
   logic load;
   logic deq;

   // ========================================================
   // next state: pointers wrap, so depth is a power of two
   always_comb
   begin
      push = en & wr_valid & wr_ready_ff;
      deq = en & out_valid_ff & rd_ready;
      load = en & (cnt_ff != '0) & (~out_valid_ff | rd_ready);
      nxt_wp = push ? wp_ff + AW'(1) : wp_ff;
      nxt_rp = load ? rp_ff + AW'(1) : rp_ff;
      nxt_cnt = cnt_ff + CW'(push) - CW'(load);
      nxt_out_data = load ? mem_ff[rp_ff] : out_data_ff;
      nxt_out_valid = load | (out_valid_ff & ~deq);
      nxt_wr_ready = nxt_cnt < CW'(DEPTH);
   end

   // storage array, no reset needed
   always_ff @(posedge ref_clk)
   begin
      if (push)
      begin
         mem_ff[wp_ff] <= wr_data;
      end
   end

   // control registers
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
         out_data_ff <= '0;
         out_valid_ff <= 1'b0;
         wr_ready_ff <= 1'b1;
      end
      else
      begin
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         cnt_ff <= nxt_cnt;
         out_data_ff <= nxt_out_data;
         out_valid_ff <= nxt_out_valid;
         wr_ready_ff <= nxt_wr_ready;
      end
   end

   assign wr_ready = wr_ready_ff;
   assign rd_data = out_data_ff;
   assign rd_valid = out_valid_ff;
endmodule
`default_nettype wire

// ===== ads_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host serial master, sclk idles low between frames
module ads_host_model
(
   input wire logic ref_clk,
   output logic cs_n,
   output logic sclk,
   output logic din,
   input wire logic dout_pin
);
   // idle levels at time zero
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #10;
   endtask
   // one frame of n bits, msb first, reply sampled before each fall
   task automatic xfer(input logic [15:0] tx, input int n,
      output logic [15:0] rx);
      rx = 16'h0000;
      cs_n = 1'b0;
      tick(2);
      for (int i = 0; i < n; i++)
      begin
         din = tx[15-i];
         tick(4);
         sclk = 1'b1;
         tick(4);
         rx = {rx[14:0], dout_pin};
         sclk = 1'b0;
         tick(1);
         din = ~din; // hold over, bit no longer shown
         tick(1);
      end
      tick(4);
      cs_n = 1'b1;
      tick(4);
   endtask
   // clock and data toggled with the port deselected
   task automatic noise(input int n);
      for (int i = 0; i < n; i++)
      begin
         sclk = ~sclk;
         din = ~din;
         tick(2);
      end
   endtask
endmodule
`default_nettype wire

// ===== ads_pkg.sv
`default_nettype none
// ==========================================================
// shared constants of the serial pin logic
package ads_pkg;
   // serial word length, in bits
   localparam int ADS_WORD_W = 16;
   // converter input and output register width
   localparam int ADS_DAC_W = 12;
   // power-up values of the converter input register
   localparam logic [11:0] ADS_DAC_FULL = 12'hfff;
   localparam logic [11:0] ADS_DAC_ZERO = 12'h000;
   // clock mode that moves the output on the rising edge
   localparam logic [1:0] ADS_MODE_RISE = 2'h3;
   // result buffer depth, in words
   localparam int ADS_FIFO_DEPTH = 16;
   // value shifted out when no result is waiting
   localparam logic [15:0] ADS_IDLE_WORD = 16'h0000;
   // port states
   typedef enum logic {ADS_IDLE, ADS_SELECTED} ads_state_e;
endpackage
`default_nettype wire

// ===== ads_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// serial host port of the converter
module ads_serial_port
   import ads_pkg::*;
#(
   parameter int WORD_W = ADS_WORD_W,
   parameter int DAC_W = ADS_DAC_W,
   parameter int FIFO_DEPTH = ADS_FIFO_DEPTH
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic [1:0] clk_mode,
   input wire logic output_load_n,
   input wire logic powerup_level_select,
   input wire logic [WORD_W-1:0] res_data,
   input wire logic res_valid,
   output logic res_ready,
   output logic dout,
   output logic dout_oe,
   output logic eoc_n,
   output logic [WORD_W-1:0] rx_word,
   output logic rx_valid,
   output logic [DAC_W-1:0] dac_in_value,
   output logic [DAC_W-1:0] dac_out_value
);
   localparam int CNT_W = $clog2(WORD_W);
   localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(WORD_W - 1);

   ads_state_e state_ff, nxt_state;
   logic sclk_q_ff, nxt_sclk_q;
   logic [WORD_W-1:0] rx_sh_ff, nxt_rx_sh;
   logic [CNT_W-1:0] rx_cnt_ff, nxt_rx_cnt;
   logic [WORD_W-1:0] tx_sh_ff, nxt_tx_sh;
   logic [CNT_W-1:0] tx_cnt_ff, nxt_tx_cnt;
   logic dout_ff, nxt_dout;
   logic dout_oe_ff, nxt_dout_oe;
   logic eoc_n_ff, nxt_eoc_n;
   logic [WORD_W-1:0] rx_word_ff, nxt_rx_word;
   logic rx_valid_ff, nxt_rx_valid;
   logic [DAC_W-1:0] dac_in_ff, nxt_dac_in;
   logic [DAC_W-1:0] dac_out_ff, nxt_dac_out;
   logic init_done_ff, nxt_init_done;
   logic sclk_rise;
   logic sclk_fall;
   logic out_edge;
   logic pop;
   logic [WORD_W-1:0] fifo_data;
   logic fifo_valid;
   logic fifo_ready;

   // ========================================================
   // helpers
   // next word to send: waiting result or idle filler
   function automatic logic [WORD_W-1:0] next_word(
      input logic valid,
      input logic [WORD_W-1:0] data
   );
      next_word = valid ? data : WORD_W'(ADS_IDLE_WORD);
   endfunction

   // one step up a bit counter
   function automatic logic [CNT_W-1:0] count_up(
      input logic [CNT_W-1:0] cnt
   );
      count_up = cnt + CNT_W'(1);
   endfunction

   // shift a word left by one, new bit in at the bottom
   function automatic logic [WORD_W-1:0] shift_in(
      input logic [WORD_W-1:0] word,
      input logic bit_in
   );
      shift_in = {word[WORD_W-2:0], bit_in};
   endfunction

   // ========================================================
   // result buffer between the converter and the serial output
   ads_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .en(clk_en),
      .wr_data(res_data),
      .wr_valid(res_valid),
      .wr_ready(fifo_ready),
      .rd_data(fifo_data),
      .rd_valid(fifo_valid),
      .rd_ready(pop)
   );

   // ========================================================
   // pin edge detection, pins sampled as synchronous inputs
   always_comb
   begin
      // edge history frozen with the rest
      nxt_sclk_q = clk_en ? sclk : sclk_q_ff;
      sclk_rise = sclk & ~sclk_q_ff;
      sclk_fall = ~sclk & sclk_q_ff;
      // output edge chosen by clock mode
      if (clk_mode == ADS_MODE_RISE)
      begin
         out_edge = sclk_rise;
      end
      else
      begin
         out_edge = sclk_fall;
      end
   end

   // edge history register; resets to the idle level of sclk
   // so that no false edge is seen right after reset
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_q_ff <= 1'b0;
      end
      else
      begin
         sclk_q_ff <= nxt_sclk_q;
      end
   end

   // ========================================================
   // serial shift engine
   always_comb
   begin
      nxt_state = state_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_rx_cnt = rx_cnt_ff;
      nxt_tx_sh = tx_sh_ff;
      nxt_tx_cnt = tx_cnt_ff;
      nxt_dout = dout_ff;
      nxt_dout_oe = dout_oe_ff;
      nxt_rx_word = rx_word_ff;
      nxt_rx_valid = 1'b0;
      pop = 1'b0;
      if (!clk_en)
      begin
         nxt_rx_valid = rx_valid_ff;
      end
      else if (cs_n)
      begin
         // deselected: float output, drop partial word
         nxt_state = ADS_IDLE;
         nxt_dout_oe = 1'b0;
         nxt_rx_cnt = '0;
         nxt_tx_cnt = '0;
      end
      else
      begin
         unique case (state_ff)
            ADS_IDLE:
            begin
               // selected: load first word and present its top bit
               nxt_state = ADS_SELECTED;
               pop = fifo_valid;
               nxt_tx_sh = next_word(fifo_valid, fifo_data);
               nxt_dout = nxt_tx_sh[WORD_W-1];
               nxt_dout_oe = 1'b1;
               nxt_rx_cnt = '0;
               nxt_tx_cnt = '0;
            end
            ADS_SELECTED:
            begin
               // input capture on falling edge
               if (sclk_fall)
               begin
                  nxt_rx_sh = shift_in(rx_sh_ff, din);
                  if (rx_cnt_ff == LAST_BIT)
                  begin
                     nxt_rx_word = nxt_rx_sh;
                     nxt_rx_valid = 1'b1;
                     nxt_rx_cnt = '0;
                  end
                  else
                  begin
                     nxt_rx_cnt = count_up(rx_cnt_ff);
                  end
               end
               // output shift on the mode's edge
               if (out_edge)
               begin
                  if (tx_cnt_ff == LAST_BIT)
                  begin
                     // word popped here is lost if cs_n rises before it is shifted out
                     pop = fifo_valid;
                     nxt_tx_sh = next_word(fifo_valid, fifo_data);
                     nxt_tx_cnt = '0;
                  end
                  else
                  begin
                     nxt_tx_sh = shift_in(tx_sh_ff, 1'b0);
                     nxt_tx_cnt = count_up(tx_cnt_ff);
                  end
                  nxt_dout = nxt_tx_sh[WORD_W-1];
               end
            end
         endcase
      end
   end

   // shift engine registers
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= ADS_IDLE;
         rx_sh_ff <= '0;
         rx_cnt_ff <= '0;
         tx_sh_ff <= '0;
         tx_cnt_ff <= '0;
         dout_ff <= 1'b0;
         dout_oe_ff <= 1'b0;
         rx_word_ff <= '0;
         rx_valid_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         rx_sh_ff <= nxt_rx_sh;
         rx_cnt_ff <= nxt_rx_cnt;
         tx_sh_ff <= nxt_tx_sh;
         tx_cnt_ff <= nxt_tx_cnt;
         dout_ff <= nxt_dout;
         dout_oe_ff <= nxt_dout_oe;
         rx_word_ff <= nxt_rx_word;
         rx_valid_ff <= nxt_rx_valid;
      end
   end

   // ========================================================
   // converter registers and end of conversion
   always_comb
   begin
      nxt_dac_in = dac_in_ff;
      nxt_dac_out = dac_out_ff;
      nxt_init_done = init_done_ff;
      nxt_eoc_n = eoc_n_ff;
      if (clk_en)
      begin
         if (!init_done_ff)
         begin
            // power-up level caught after reset release
            nxt_dac_in = powerup_level_select ? ADS_DAC_FULL
                                              : ADS_DAC_ZERO;
            nxt_init_done = 1'b1;
         end
         else if (nxt_rx_valid)
         begin
            nxt_dac_in = nxt_rx_word[DAC_W-1:0];
         end
         // holding register transparent while load is low
         if (!output_load_n)
         begin
            nxt_dac_out = nxt_dac_in;
         end
         // low while a result waits for the host
         nxt_eoc_n = ~fifo_valid;
      end
   end

   // converter registers and end of conversion flag
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         eoc_n_ff <= 1'b1;
         dac_in_ff <= ADS_DAC_ZERO;
         dac_out_ff <= ADS_DAC_ZERO;
         init_done_ff <= 1'b0;
      end
      else
      begin
         eoc_n_ff <= nxt_eoc_n;
         dac_in_ff <= nxt_dac_in;
         dac_out_ff <= nxt_dac_out;
         init_done_ff <= nxt_init_done;
      end
   end

   // outputs straight from flip-flops
   assign res_ready = fifo_ready;
   assign dout = dout_ff;
   assign dout_oe = dout_oe_ff;
   assign eoc_n = eoc_n_ff;
   assign rx_word = rx_word_ff;
   assign rx_valid = rx_valid_ff;
   assign dac_in_value = dac_in_ff;
   assign dac_out_value = dac_out_ff;
endmodule
`default_nettype wire

// ===== ads_sp_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// pin timing relations of the serial port
module ads_sp_properties
   import ads_pkg::*;
#(
   parameter int WORD_W = ADS_WORD_W,
   parameter int DAC_W = ADS_DAC_W
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic [1:0] clk_mode,
   input wire logic output_load_n,
   input wire logic powerup_level_select,
   input wire logic [WORD_W-1:0] res_data,
   input wire logic res_valid,
   input wire logic res_ready,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic eoc_n,
   input wire logic [WORD_W-1:0] rx_word,
   input wire logic rx_valid,
   input wire logic [DAC_W-1:0] dac_in_value,
   input wire logic [DAC_W-1:0] dac_out_value
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // pin state and output edges
   cs_hiz_a: assert property (cs_n && $past(cs_n) |-> !dout_oe)
      else $error("dout driven while deselected");
   fall_edge_a: assert property ($changed(dout) && dout_oe
      && $past(dout_oe) && clk_mode != ADS_MODE_RISE |-> !$past(sclk))
      else $error("late dout");
   rise_edge_a: assert property ($changed(dout) && dout_oe
      && $past(dout_oe) && clk_mode == ADS_MODE_RISE |-> $past(sclk))
      else $error("early dout");
   // received words and converter registers
   rx_dac_a: assert property (rx_valid
      |-> dac_in_value == rx_word[DAC_W-1:0])
      else $error("dac input not from word");
   quiet_port_a: assert property (cs_n && $past(cs_n) && $past(cs_n, 2)
      |-> !rx_valid) else $error("word while deselected");
   load_follow_a: assert property ($past(!output_load_n)
      |-> dac_out_value == dac_in_value) else $error("load not transparent");
   // result flag and power-up value
   eoc_push_a: assert property ($fell(eoc_n) |-> $past(res_valid, 2)
      || $past(res_valid, 3) || $past(res_valid, 4))
      else $error("eoc fell alone");
   full_eoc_a: assert property (!res_ready |-> !eoc_n)
      else $error("full buffer without eoc");
   powerup_a: assert property (!$past(rst_n, 2) && $past(rst_n) |->
      dac_in_value == ($past(powerup_level_select)
      ? ADS_DAC_FULL : ADS_DAC_ZERO))
      else $error("power-up value wrong");
endmodule
bind ads_serial_port ads_sp_properties #(.WORD_W(WORD_W), .DAC_W(DAC_W)) u_props
   (.ref_clk, .rst_n, .clk_en, .cs_n, .sclk, .din, .clk_mode, .output_load_n,
   .powerup_level_select, .res_data, .res_valid, .res_ready, .dout, .dout_oe,
   .eoc_n, .rx_word, .rx_valid, .dac_in_value, .dac_out_value);
`default_nettype wire

// ===== tb_ads_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench of the serial port
module tb_ads_serial_port
   import ads_pkg::*;
;
   logic ref_clk = 1'b0, rst_n = 1'b0, res_valid = 1'b0, dout_last = 1'b0;
   logic output_load_n = 1'b1, powerup_level_select = 1'b1;
   logic clk_en = 1'b1;
   logic [1:0] clk_mode = 2'h0;
   logic [15:0] res_data = 16'h0000, rx_word, rx;
   logic res_ready, dout, dout_oe, eoc_n, rx_valid;
   logic [11:0] dac_in_value, dac_out_value;
   wire logic cs_n, sclk, din, dout_pin;
   int bad_count = 0, total_checks = 0;
   int rx_count = 0;
   bit ok;
   // clock and the pin level seen by the host
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (dout_oe === 1'b1) dout_last <= dout;
   assign dout_pin = (dout_oe === 1'b1) ? dout : ~dout_last;
   // received word pulses, counted away from the launching edge
   always @(negedge ref_clk) if (rx_valid === 1'b1) rx_count++;
   ads_host_model u_host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk),
      .din(din), .dout_pin(dout_pin));
   ads_serial_port u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
      .cs_n(cs_n), .sclk(sclk), .din(din), .clk_mode(clk_mode),
      .output_load_n(output_load_n),
      .powerup_level_select(powerup_level_select), .res_data(res_data),
      .res_valid(res_valid), .res_ready(res_ready), .dout(dout),
      .dout_oe(dout_oe), .eoc_n(eoc_n), .rx_word(rx_word),
      .rx_valid(rx_valid), .dac_in_value(dac_in_value),
      .dac_out_value(dac_out_value));
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #10;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // offer one result, held until taken or refused three times
   task automatic push(input logic [15:0] w, output bit taken);
      taken = 1'b0;
      res_data = w;
      res_valid = 1'b1;
      for (int i = 0; i < 3 && !taken; i++)
      begin
         taken = (res_ready === 1'b1);
         tick(1);
      end
      res_valid = 1'b0;
      tick(1); // one idle edge before the next offer
   endtask
   task automatic wait_eoc(input logic lvl);
      for (int i = 0; i < 20 && eoc_n !== lvl; i++) tick(1);
      check(16'(eoc_n), 16'(lvl));
      if (eoc_n !== lvl) test_done();
   endtask
   task automatic t_powerup(input logic sel, input logic [11:0] exp);
      rst_n = 1'b0;
      powerup_level_select = sel;
      tick(4);
      rst_n = 1'b1;
      tick(3);
      check({4'h0, dac_in_value}, {4'h0, exp});
   endtask
   task automatic t_load();
      u_host.xfer(16'h0abc, 16, rx);
      check({4'h0, dac_out_value}, 16'h0000);
      check({4'h0, dac_in_value}, 16'h0abc);
      output_load_n = 1'b0;
      tick(2);
      check({4'h0, dac_out_value}, 16'h0abc);
      output_load_n = 1'b1;
      u_host.xfer(16'h0123, 16, rx);
      check({4'h0, dac_out_value}, 16'h0abc);
      check({4'h0, dac_in_value}, 16'h0123);
   endtask
   task automatic t_modes();
      for (int m = 0; m < 4; m++)
      begin
         clk_mode = 2'(m);
         push(16'h9a50 | 16'(m), ok);
         wait_eoc(1'b0);
         u_host.xfer(16'h0e30 | 16'(m), 16, rx);
         check(rx_word, 16'h0e30 | 16'(m));
         // mode 11: top bit already left at the first rise
         if (m == 3)
            check(rx, (16'h9a50 | 16'(m)) << 1);
         else
            check(rx, 16'h9a50 | 16'(m));
         check(16'(dout_oe), 16'h0000);
      end
      clk_mode = 2'h0;
   endtask
   task automatic t_fifo();
      int n = 0;
      ok = 1'b1;
      while (ok && n < 20)
      begin
         push(16'hc000 | 16'(n), ok);
         if (ok) n++;
      end
      check(16'(n), 16'(ADS_FIFO_DEPTH + 1));
      // each frame also pops the word behind it at its last edge
      for (int i = 0; i < n; i += 2)
      begin
         u_host.xfer(16'h0000, 16, rx);
         check(rx, 16'hc000 | 16'(i));
      end
      u_host.xfer(16'h0000, 16, rx);
      check(rx, ADS_IDLE_WORD);
      wait_eoc(1'b1);
   endtask
   task automatic t_abort();
      int words;
      words = rx_count;
      u_host.xfer(16'hffff, 7, rx);
      u_host.xfer(16'h1234, 16, rx);
      check(16'(rx_count - words), 16'h0001);
      check(rx_word, 16'h1234);
      u_host.noise(20);
      check(rx_word, 16'h1234);
      check(16'(dout_oe), 16'h0000);
   endtask
   // offers and frames ignored while the clock enable is low
   task automatic t_freeze();
      clk_en = 1'b0;
      push(16'h5a5a, ok);
      u_host.xfer(16'h0fed, 16, rx);
      clk_en = 1'b1;
      tick(4);
      check(16'(eoc_n), 16'h0001);
      check(rx_word, 16'h1234);
   endtask
   // main sequence
   initial
   begin
      t_powerup(1'b1, ADS_DAC_FULL);
      t_load();
      t_modes();
      t_fifo();
      t_abort();
      t_freeze();
      t_powerup(1'b0, ADS_DAC_ZERO);
      test_done();
   end
endmodule
`default_nettype wire
